// >>> logic/imte_top.sv
// I2C master transaction engine with APB registers
//
// Overview of operation
// [R01] Only this master originates START and STOP and starts every transaction.
// [R02] Start bit produces START: SDA falls while SCL is high.
// [R03] Stop bit produces STOP: SDA rises while SCL is high.
// [R04] Start bit set at transaction end gives a repeated START.
// [R05] START waits for both start bit and a written data byte; a repeated START here does not wait for the byte.
// [R06] Software sets transmit enable per transaction and clears it at the end.
// [R07] Master write stalls at acknowledge start while transmit data empty.
// [R08] Stalled acknowledge clock is issued just ahead of the next byte.
// [R09] No stall before acknowledge when start or stop is already set.
// [R10] Write NACK sets nack flag and holds bus until start or stop.
// [R11] Flush with start or stop discards stale transmit byte.
// [R12] Master read stalls after data acknowledge until receive flag clears.
// [R13] DMA reads n-1 bytes; software forces NACK and reads the last.
// [R14] Idle and START are codes 0 and 1; data bits 0_0010 to 0_1001.
// [R15] Data acknowledge is 0_1010; 0_1011 only with not-acknowledge.
// [R16] STOP spans codes 0_1100 then 0_1101.
// [R17] Seven-bit address uses 1_1001..1_1111, R/W 0_1111, acknowledge 0_1110.
// [R18] Ten-bit first byte uses 1_0000..1_0111, acknowledge 1_1000.
// [R19] Readback select returns baud reload when 0, live counter when 1.
// [R20] Software paces on empty, full and nack flags, not acknowledge bit.
// [R21] Shift-state code readable every cycle as a read-only field.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "imte_params.svh"
module imte_top
  import imte_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Status
  output logic tx_interrupt_request
);

  localparam imte_code_t S_IDLE = 5'h00;
  localparam imte_code_t S_START = 5'h01;
  localparam imte_code_t S_D7 = 5'h02;
  localparam imte_code_t S_D0 = 5'h09;
  localparam imte_code_t S_DACK = 5'h0a;
  localparam imte_code_t S_DNAK = 5'h0b;
  localparam imte_code_t S_STOP1 = 5'h0c;
  localparam imte_code_t S_STOP2 = 5'h0d;
  localparam imte_code_t S_AACK = 5'h0e;
  localparam imte_code_t S_ARW = 5'h0f;
  localparam imte_code_t S_X7 = 5'h10;
  localparam imte_code_t S_X0 = 5'h17;
  localparam imte_code_t S_XACK = 5'h18;
  localparam imte_code_t S_A7 = 5'h19;
  localparam imte_code_t S_A1 = 5'h1f;

  function automatic logic is_bit_state(input imte_code_t s);
    is_bit_state = (s >= S_D7 && s <= S_D0) || s == S_ARW || (s >= S_X7 && s <= S_X0)
      || s >= S_A7;
  endfunction

  function automatic logic is_ack_state(input imte_code_t s);
    is_ack_state = s == S_DACK || s == S_AACK || s == S_XACK;
  endfunction

  // Pin synchronisers
  logic [1:0] scl_sync_reg, sda_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end
  logic scl_s, sda_s;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];

  // State registers
  logic [7:0] tx_reg, tx_next, sh_reg, sh_next, rx_reg, rx_next;
  logic tx_data_empty_flag_reg, tx_data_empty_flag_next, rx_data_full_flag_reg, rx_data_full_flag_next, nack_interrupt_flag_reg, nack_interrupt_flag_next, ack_reg, ack_next;
  logic start_reg, start_next, stop_reg, stop_next, nak_reg, nak_next;
  logic txi_reg, txi_next, a10_reg, a10_next, readback_select_reg, readback_select_next;
  logic rd_reg, rd_next, addr_reg, addr_next, hold_reg, hold_next;
  logic [15:0] brg_reg, brg_next, cnt_reg, cnt_next;
  imte_code_t st_reg, st_next;
  imte_phase_t ph_reg, ph_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic [31:0] prdata_next;
  logic pready_reg, pready_next, pslverr_next;

  logic wr_acc, rd_acc, tick;
  assign wr_acc = psel && penable && pwrite && !pready_reg;
  assign rd_acc = psel && penable && !pwrite && !pready_reg;
  assign tick = cnt_reg == 16'h0000;

  always_comb begin
    tx_next = tx_reg;
    sh_next = sh_reg;
    rx_next = rx_reg;
    tx_data_empty_flag_next = tx_data_empty_flag_reg;
    rx_data_full_flag_next = rx_data_full_flag_reg;
    nack_interrupt_flag_next = nack_interrupt_flag_reg;
    ack_next = ack_reg;
    start_next = start_reg;
    stop_next = stop_reg;
    nak_next = nak_reg;
    txi_next = txi_reg;
    a10_next = a10_reg;
    readback_select_next = readback_select_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    hold_next = hold_reg;
    brg_next = brg_reg;
    cnt_next = tick ? brg_reg : cnt_reg - 16'h0001;
    st_next = st_reg;
    ph_next = ph_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    prdata_next = 32'h0000_0000;
    pready_next = psel && penable && !pready_reg;
    pslverr_next = 1'b0;
    // Register writes first; engine events below win over clears
    if (wr_acc) begin
      case (paddr)
        `IMTE_OFF_DATA: begin
          tx_next = pwdata[7:0];
          tx_data_empty_flag_next = 1'b0;
        end
        `IMTE_OFF_CTRL: begin
          start_next = start_reg | pwdata[`IMTE_CTRL_START];
          stop_next = stop_reg | pwdata[`IMTE_CTRL_STOP];
          nak_next = pwdata[`IMTE_CTRL_NAK];
          txi_next = pwdata[`IMTE_CTRL_TXI];
          a10_next = pwdata[`IMTE_CTRL_ADDR10];
          if (pwdata[`IMTE_CTRL_FLUSH] && nack_interrupt_flag_reg) begin
            tx_data_empty_flag_next = 1'b1; // [R11]
            nack_interrupt_flag_next = 1'b0;
          end
        end
        `IMTE_OFF_BRH: brg_next[15:8] = pwdata[7:0];
        `IMTE_OFF_BRL: brg_next[7:0] = pwdata[7:0];
        `IMTE_OFF_READBACK_SELECT: readback_select_next = pwdata[`IMTE_READBACK_SELECT_SEL];
        `IMTE_OFF_STAT: ;
        default: pslverr_next = 1'b1;
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        `IMTE_OFF_DATA: begin
          prdata_next[7:0] = rx_reg;
          rx_data_full_flag_next = 1'b0;
        end
        `IMTE_OFF_STAT: begin
          prdata_next[`IMTE_STAT_TX_DATA_EMPTY_FLAG] = tx_data_empty_flag_reg;
          prdata_next[`IMTE_STAT_RX_DATA_FULL_FLAG] = rx_data_full_flag_reg;
          prdata_next[`IMTE_STAT_NACK_INTERRUPT_FLAG] = nack_interrupt_flag_reg;
          prdata_next[`IMTE_STAT_ACK] = ack_reg;
          prdata_next[`IMTE_STAT_SS +: 5] = st_reg; // [R21]
        end
        `IMTE_OFF_CTRL: prdata_next[5:0] = {a10_reg, txi_reg, nak_reg, 1'b0, stop_reg, start_reg};
        `IMTE_OFF_BRH: prdata_next[7:0] = readback_select_reg ? cnt_reg[15:8] : brg_reg[15:8]; // [R19]
        `IMTE_OFF_BRL: prdata_next[7:0] = readback_select_reg ? cnt_reg[7:0] : brg_reg[7:0]; // [R19]
        `IMTE_OFF_READBACK_SELECT: prdata_next[0] = readback_select_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
    // Four phases per bit: A set SDA (SCL low), B raise SCL, C sample, D lower SCL
    if (tick) begin
      case (st_reg)
        S_IDLE: begin
          scl_next = 1'b1;
          sda_next = 1'b1;
          if (start_reg && !tx_data_empty_flag_reg) begin // [R01] [R05]
            st_next = S_START;
            ph_next = PH_A;
          end
        end
        S_START: begin
          case (ph_reg)
            PH_A: begin
              sda_next = 1'b1;
              ph_next = PH_B;
            end
            PH_B: begin
              scl_next = 1'b1;
              ph_next = PH_C;
            end
            PH_C: begin
              sda_next = 1'b0; // [R02] [R04]
              ph_next = PH_D;
            end
            default: begin
              scl_next = 1'b0;
              start_next = 1'b0;
              sh_next = tx_reg;
              tx_data_empty_flag_next = 1'b1;
              rd_next = tx_reg[0];
              addr_next = 1'b1;
              st_next = a10_reg ? S_X7 : S_A7; // [R17] [R18]
              ph_next = PH_A;
            end
          endcase
        end
        S_STOP1: begin
          // SDA goes low under a low clock first, so the low phase keeps its length
          if (ph_reg == PH_A) begin
            sda_next = 1'b0;
            ph_next = PH_B;
          end else begin
            scl_next = 1'b1;
            ph_next = PH_A;
            st_next = S_STOP2; // [R16]
          end
        end
        S_STOP2: begin
          sda_next = 1'b1; // [R03]
          stop_next = 1'b0;
          st_next = S_IDLE;
        end
        default: begin
          case (ph_reg)
            PH_A: begin
              if (is_ack_state(st_reg)) begin
                // Write-side ACK: SDA released. Read-side: drive ACK unless NAK forced
                sda_next = (rd_reg && !addr_reg) ? nak_reg : 1'b1;
                if ((!rd_reg || st_reg == S_XACK) && tx_data_empty_flag_reg && !start_reg && !stop_reg)
                  hold_next = 1'b1; // [R07] [R09]
                // A late start or stop also ends the stall: no further byte follows
                if (hold_reg && (!tx_data_empty_flag_reg || start_reg || stop_reg))
                  hold_next = 1'b0; // [R08]
                if (!hold_next)
                  ph_next = PH_B;
              end else begin
                sda_next = (rd_reg && !addr_reg && st_reg <= S_D0) ? 1'b1 : sh_reg[7];
                ph_next = PH_B;
              end
            end
            PH_B: begin
              scl_next = 1'b1;
              if (scl_s)
                ph_next = PH_C;
            end
            PH_C: begin
              if (is_bit_state(st_reg))
                sh_next = {sh_reg[6:0], sda_s};
              else
                ack_next = !sda_s;
              ph_next = PH_D;
            end
            default: begin
              scl_next = 1'b0;
              ph_next = PH_A;
              case (st_reg)
                S_X0: st_next = S_XACK;
                S_A1: st_next = S_ARW;
                S_ARW: st_next = S_AACK;
                S_D0: begin
                  st_next = S_DACK;
                  if (rd_reg) begin
                    rx_next = sh_reg;
                    rx_data_full_flag_next = 1'b1;
                  end
                end
                S_XACK, S_AACK, S_DACK: begin
                  if (!ack_reg && !(rd_reg && !addr_reg)) begin
                    nack_interrupt_flag_next = 1'b1; // [R10]
                    st_next = S_DNAK; // [R15]
                  end else if (st_reg == S_XACK) begin
                    sh_next = tx_reg;
                    tx_data_empty_flag_next = 1'b1;
                    st_next = S_A7;
                  end else if (start_reg) begin
                    st_next = S_START;
                  end else if (stop_reg) begin
                    st_next = S_STOP1;
                  end else if (rd_reg) begin
                    addr_next = 1'b0;
                    st_next = S_D7; // [R12]
                  end else begin
                    addr_next = 1'b0;
                    sh_next = tx_reg;
                    tx_data_empty_flag_next = 1'b1;
                    st_next = S_D7;
                  end
                end
                default: st_next = st_reg + 5'h01; // [R14]
              endcase
            end
          endcase
        end
      endcase
      // Bus hold states
      if (st_reg == S_DNAK) begin
        scl_next = 1'b0;
        if (start_reg) begin
          st_next = S_START; // [R10]
          ph_next = PH_A;
        end else if (stop_reg) begin
          st_next = S_STOP1;
          ph_next = PH_A;
        end
      end
      if (st_reg == S_D7 && ph_reg == PH_A && rd_reg && rx_data_full_flag_reg)
        ph_next = PH_A; // [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 8'h00;
      sh_reg <= 8'h00;
      rx_reg <= 8'h00;
      tx_data_empty_flag_reg <= 1'b1;
      rx_data_full_flag_reg <= 1'b0;
      nack_interrupt_flag_reg <= 1'b0;
      ack_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      nak_reg <= 1'b0;
      txi_reg <= 1'b0;
      a10_reg <= 1'b0;
      readback_select_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 1'b0;
      hold_reg <= 1'b0;
      brg_reg <= `IMTE_BRG_RESET;
      cnt_reg <= `IMTE_BRG_RESET;
      st_reg <= 5'h00;
      ph_reg <= PH_A;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      prdata <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      tx_interrupt_request <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      sh_reg <= sh_next;
      rx_reg <= rx_next;
      tx_data_empty_flag_reg <= tx_data_empty_flag_next;
      rx_data_full_flag_reg <= rx_data_full_flag_next;
      nack_interrupt_flag_reg <= nack_interrupt_flag_next;
      ack_reg <= ack_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
      nak_reg <= nak_next;
      txi_reg <= txi_next;
      a10_reg <= a10_next;
      readback_select_reg <= readback_select_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      hold_reg <= hold_next;
      brg_reg <= brg_next;
      cnt_reg <= cnt_next;
      st_reg <= st_next;
      ph_reg <= ph_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      prdata <= prdata_next;
      pready_reg <= pready_next;
      pslverr <= pslverr_next;
      // Open drain: drive low only
      scl_out <= 1'b0;
      scl_oe <= !scl_next;
      sda_out <= 1'b0;
      sda_oe <= !sda_next;
      tx_interrupt_request <= txi_next && tx_data_empty_flag_next && !nack_interrupt_flag_next;
    end
  end
  assign pready = pready_reg;

endmodule

// >>> logic/imte_params.svh
// Register offsets, field positions, reset values and timing counts for the I2C engine
`ifndef IMTE_PARAMS_SVH
`define IMTE_PARAMS_SVH
`define IMTE_OFF_DATA 12'h000
`define IMTE_OFF_STAT 12'h004
`define IMTE_OFF_CTRL 12'h008
`define IMTE_OFF_BRH 12'h00c
`define IMTE_OFF_BRL 12'h010
`define IMTE_OFF_READBACK_SELECT 12'hf56
`define IMTE_CTRL_START 0
`define IMTE_CTRL_STOP 1
`define IMTE_CTRL_FLUSH 2
`define IMTE_CTRL_NAK 3
`define IMTE_CTRL_TXI 4
`define IMTE_CTRL_ADDR10 5
`define IMTE_STAT_TX_DATA_EMPTY_FLAG 0
`define IMTE_STAT_RX_DATA_FULL_FLAG 1
`define IMTE_STAT_NACK_INTERRUPT_FLAG 2
`define IMTE_STAT_ACK 3
`define IMTE_STAT_SS 8
`define IMTE_READBACK_SELECT_SEL 0
`define IMTE_BRG_RESET 16'h0004
`endif

// >>> logic/imte_pkg.sv
// Types for the I2C master transaction engine
package imte_pkg;
  typedef enum logic [1:0] {PH_A, PH_B, PH_C, PH_D} imte_phase_t;
  typedef logic [4:0] imte_code_t;
endpackage

// >>> verification/imte_properties.sv
// Port-level assertions for the I2C engine
`timescale 1ns/1ns
module imte_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Bus drivers
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Edges of SDA while SCL is released
  sequence s_start;
    $rose(sda_oe) && !scl_oe && $past(!scl_oe);
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe && $past(!scl_oe);
  endsequence
  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("no pready one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && psel)
    else $error("pslverr outside an answer");
  a_start_hold: assert property (s_start |-> !scl_oe [*2])
    else $error("clock pulled too soon after start");
  a_start_clock: assert property (s_start |-> ##[1:40] scl_oe)
    else $error("no clock after start");
  a_stop_free: assert property (s_stop |=> (!scl_oe && !sda_oe) [*3])
    else $error("bus not free after stop");
  a_scl_low: assert property ($rose(scl_oe) |-> scl_oe [*3])
    else $error("clock low phase too short");
  a_scl_high: assert property ($fell(scl_oe) |-> !scl_oe [*3])
    else $error("clock high phase too short");
endmodule

// >>> verification/imte_slave_model.sv
// Behavioural I2C slave: acknowledges each byte, or refuses on request
`timescale 1ns/1ns
module imte_slave_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Test control
  input wire logic nack_all,
  output logic sda_pull
);
  int bits = 0;
  initial sda_pull = 0;
  // START or STOP restarts the byte count
  always @(sda) if (scl) bits = 0;
  always @(posedge scl) bits++;
  // Ack only within the ninth clock, never framing the bus
  always @(negedge scl) begin
    if (bits == 8) begin
      sda_pull <= !nack_all;
    end else if (bits == 9) begin
      sda_pull <= 0;
      bits = 0;
    end
  end
endmodule

// >>> verification/i2c_master_transaction_engine_test.sv
// Bench for the I2C engine: APB tasks and directed sequences
`timescale 1ns/1ns
`include "imte_params.svh"
module i2c_master_transaction_engine_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nack_all = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, serr, scl_out, scl_oe, sda_out, sda_oe, irq, pull;
  int err_total = 0, samples_checked = 0;
  // Open-drain lines with pull-ups
  wire scl = !scl_oe;
  wire sda = !(sda_oe || pull);
  always #20 pclk = ~pclk;
  imte_top imte_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .tx_interrupt_request(irq));
  imte_slave_model imte_slave_model_i (.scl(scl), .sda(sda), .nack_all(nack_all),
    .sda_pull(pull));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer, then an idle cycle so strobes never toggle twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (pready !== 1'b1 && n >= 20) begin
      chk("apb answer", 0, 1);
      give_verdict();
    end
  endtask
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int n = 0;
    do begin
      apb(0, `IMTE_OFF_STAT, 0);
      n++;
    end while ((q & m) !== v && n < 200);
    chk("status", q & m, v);
    if ((q & m) !== v)
      give_verdict();
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `IMTE_OFF_STAT, 0);
    chk("status reset", q & 32'h1f07, 32'h1);
    apb(0, `IMTE_OFF_BRL, 0);
    chk("reload reset", q, 32'h4);
    apb(0, `IMTE_OFF_READBACK_SELECT, 0);
    chk("readback_select reset", q, 32'h0);
    apb(0, 12'h020, 0);
    chk("unmapped", serr, 1);
    // Baud 1 gives a 480 ns link clock
    apb(1, `IMTE_OFF_BRL, 1);
    apb(1, `IMTE_OFF_READBACK_SELECT, 1);
    apb(0, `IMTE_OFF_READBACK_SELECT, 0);
    chk("readback_select select", q, 32'h1);
    apb(0, `IMTE_OFF_BRL, 0);
    chk("live count", q <= 1, 1);
    apb(1, `IMTE_OFF_READBACK_SELECT, 0);
    apb(0, `IMTE_OFF_BRL, 0);
    chk("reload", q, 32'h1);
    apb(1, `IMTE_OFF_CTRL, 32'h11);
    repeat (40) @(posedge pclk);
    chk("irq empty", irq, 1);
    chk("no start", sda_oe, 0);
    apb(1, `IMTE_OFF_DATA, 32'ha0);
    repeat (2) @(posedge pclk);
    chk("irq filled", irq, 0);
    wait_stat(32'h1f00, 32'h0e00);
    repeat (60) @(posedge pclk);
    chk("clock held", scl_oe, 1);
    wait_stat(32'h1f00, 32'h0e00);
    apb(1, `IMTE_OFF_DATA, 32'h3c);
    wait_stat(32'h1f00, 32'h0a00);
    apb(1, `IMTE_OFF_CTRL, 32'h2);
    wait_stat(32'h1f05, 32'h1);
    chk("sda free", sda, 1);
    // Stop requested before the acknowledge: no stall allowed
    apb(1, `IMTE_OFF_CTRL, 32'h1);
    apb(1, `IMTE_OFF_DATA, 32'ha0);
    apb(1, `IMTE_OFF_CTRL, 32'h2);
    wait_stat(32'h1f05, 32'h1);
    nack_all <= 1;
    apb(1, `IMTE_OFF_CTRL, 32'h1);
    apb(1, `IMTE_OFF_DATA, 32'ha0);
    wait_stat(32'h1, 32'h1);
    apb(1, `IMTE_OFF_DATA, 32'h55);
    wait_stat(32'h1f04, 32'h0b04);
    repeat (60) @(posedge pclk);
    wait_stat(32'h1f04, 32'h0b04);
    nack_all <= 0;
    apb(1, `IMTE_OFF_CTRL, 32'h16);
    wait_stat(32'h1f05, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq again", irq, 1);
    // Read: released bus gives all ones; engine waits while receive data is full
    apb(1, `IMTE_OFF_CTRL, 32'h1);
    apb(1, `IMTE_OFF_DATA, 32'ha1);
    wait_stat(32'h1f02, 32'h0202);
    repeat (60) @(posedge pclk);
    wait_stat(32'h1f02, 32'h0202);
    apb(1, `IMTE_OFF_CTRL, 32'ha);
    apb(0, `IMTE_OFF_DATA, 0);
    chk("read byte", q, 32'hff);
    wait_stat(32'h1f03, 32'h0003);
    apb(0, `IMTE_OFF_DATA, 0);
    chk("last byte", q, 32'hff);
    give_verdict();
  end
endmodule
bind imte_top imte_properties imte_properties_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .scl_oe(scl_oe),
  .sda_oe(sda_oe));
